// >>> common/xdl_pkg.sv
// Package for the exclusive-OR and direction-load execution block.
// Assumes an 8-bit core with a 128-byte file space and three ports.
package xdl_pkg;
  localparam int          XDL_DATA_W      = 8;
  localparam int          XDL_ADDR_W      = 7;
  localparam int          XDL_SEL_W       = 3;
  // Direction-load operand values that select each port.
  localparam logic [2:0]  XDL_SEL_PORT_A  = 3'h5;
  localparam logic [2:0]  XDL_SEL_PORT_B  = 3'h6;
  localparam logic [2:0]  XDL_SEL_PORT_C  = 3'h7;
  // Reset values: direction registers reset to all inputs.
  localparam logic [7:0]  XDL_DIR_RESET   = 8'hFF;
  localparam logic [7:0]  XDL_W_RESET     = 8'h00;
  // Destination bit encodings for the file exclusive-OR.
  localparam logic        XDL_DEST_W      = 1'b0;
  localparam logic        XDL_DEST_FILE   = 1'b1;
  // Register port offsets for the software view.
  localparam logic [3:0]  XDL_REG_W       = 4'h0;
  localparam logic [3:0]  XDL_REG_STATUS  = 4'h1;
  localparam logic [3:0]  XDL_REG_DIR_A   = 4'h2;
  localparam logic [3:0]  XDL_REG_DIR_B   = 4'h3;
  localparam logic [3:0]  XDL_REG_DIR_C   = 4'h4;
  localparam int          XDL_REG_ADDR_W  = 4;
  // Status field positions.
  localparam int          XDL_ST_ZERO     = 0;
  localparam int          XDL_ST_BADSEL   = 1;
  typedef enum logic [1:0] {
    XDL_OP_NONE = 2'h0,
    XDL_OP_DIR  = 2'h1,
    XDL_OP_XORF = 2'h3,
    XDL_OP_XORL = 2'h2
  } xdl_op_t;
endpackage

// >>> rtl/xdl_dir_decode.sv
// Decoder for the direction-load operand.
// An operand that names no port is reported as illegal through the legal output.
`timescale 1ns/100ps
module xdl_dir_decode
  import xdl_pkg::*;
(
  input  wire logic [XDL_SEL_W-1:0] sel,
  output logic      [2:0]           onehot,
  output logic                      legal
);
  // Only operands five to seven name a port; others select nothing.
  always_comb begin
    onehot    = 3'h0;
    onehot[0] = (sel == XDL_SEL_PORT_A); // see [RULE2]
    onehot[1] = (sel == XDL_SEL_PORT_B); // see [RULE2]
    onehot[2] = (sel == XDL_SEL_PORT_C); // see [RULE2]
    legal     = |onehot;                 // see [RULE1]
  end
endmodule

// >>> rtl/xdl_exec.sv
// Execution of direction-load and the two exclusive-OR instructions.
// Assumes one instruction per cycle with file data read combinationally.
//
// Function
// [RULE1] Direction load takes operand 5..7, flags kept.
// [RULE2] Operand 5,6,7 selects port A,B,C direction.
// [RULE3] Literal XOR into working register, zero only.
// [RULE4] File XOR on address 0..127, zero only.
// [RULE5] Destination bit 0 to W, 1 to file.
// [RULE6] Zero flag set when XOR result is zero.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module xdl_exec
  import xdl_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic                      op_valid,
  input  wire logic [1:0]                op_code,
  input  wire logic [XDL_DATA_W-1:0]     literal,
  input  wire logic [XDL_ADDR_W-1:0]     file_addr,
  input  wire logic                      dest,
  input  wire logic [XDL_SEL_W-1:0]      dir_sel,
  input  wire logic [XDL_DATA_W-1:0]     file_rdata,
  input  wire logic [XDL_REG_ADDR_W-1:0] reg_addr,
  input  wire logic [XDL_DATA_W-1:0]     reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [XDL_DATA_W-1:0]     reg_rdata,
  output logic      [XDL_ADDR_W-1:0]     file_waddr,
  output logic      [XDL_DATA_W-1:0]     file_wdata,
  output logic                           file_we,
  output logic      [XDL_DATA_W-1:0]     work_reg,
  output logic                           zero_flag,
  output logic      [XDL_DATA_W-1:0]     port_a_direction,
  output logic      [XDL_DATA_W-1:0]     port_b_direction,
  output logic      [XDL_DATA_W-1:0]     port_c_direction
);
  typedef struct packed {
    // Working register and its zero flag.
    logic [XDL_DATA_W-1:0] w;
    logic                  z;
    // Sticky record of a direction load with an unusable operand.
    logic                  badsel;
    // The three port direction registers.
    logic [XDL_DATA_W-1:0] dir_a;
    logic [XDL_DATA_W-1:0] dir_b;
    logic [XDL_DATA_W-1:0] dir_c;
    // Registered file write-back, one cycle per result.
    logic [XDL_ADDR_W-1:0] waddr;
    logic [XDL_DATA_W-1:0] wdata;
    logic                  we;
    // Read data, zero except in the cycle after a read strobe.
    logic [XDL_DATA_W-1:0] rdata;
  } xdl_state_t;

  xdl_state_t            state_reg;
  xdl_state_t            state_next;
  xdl_op_t               op;
  logic [XDL_DATA_W-1:0] xor_in;
  logic [XDL_DATA_W-1:0] xor_y;
  logic                  xor_zero;
  logic [2:0]            dir_hit;
  logic                  dir_legal;

  // Register-port read decoding, shared by the read mux.
  function automatic logic [XDL_DATA_W-1:0] read_mux(
    input xdl_state_t            s,
    input logic [XDL_REG_ADDR_W-1:0] a
  );
    logic [XDL_DATA_W-1:0] r;
    r = '0;
    case (a)
      XDL_REG_W:      r = s.w;
      XDL_REG_STATUS: begin
        r[XDL_ST_ZERO]   = s.z;
        r[XDL_ST_BADSEL] = s.badsel;
      end
      XDL_REG_DIR_A:  r = s.dir_a;
      XDL_REG_DIR_B:  r = s.dir_b;
      XDL_REG_DIR_C:  r = s.dir_c;
      default:        r = '0;
    endcase
    return r;
  endfunction

  assign op     = xdl_op_t'(op_code);
  // The second operand is the literal or the addressed file byte.
  assign xor_in = (op == XDL_OP_XORL) ? literal : file_rdata;

  xdl_xor_unit #(
    .WIDTH (XDL_DATA_W)
  ) u_xor (
    .a    (state_reg.w),
    .b    (xor_in),
    .y    (xor_y),
    .zero (xor_zero)
  );

  xdl_dir_decode u_dec (
    .sel    (dir_sel),
    .onehot (dir_hit),
    .legal  (dir_legal)
  );

  // Next-state logic; instructions win over a same-cycle software write
  // to W so the executing program never sees its result overwritten.
  always_comb begin
    state_next       = state_reg;
    state_next.we    = 1'b0;
    state_next.rdata = '0;
    // Software writes come first, so an instruction below overrides them.
    if (reg_write) begin
      case (reg_addr)
        XDL_REG_W:     state_next.w     = reg_wdata;
        XDL_REG_DIR_A: state_next.dir_a = reg_wdata;
        XDL_REG_DIR_B: state_next.dir_b = reg_wdata;
        XDL_REG_DIR_C: state_next.dir_c = reg_wdata;
        XDL_REG_STATUS: state_next.badsel = 1'b0;
        default: ;
      endcase
    end
    // Instruction effects; an unused code leaves every register alone.
    if (op_valid) begin
      case (op)
        XDL_OP_DIR: begin
          // The zero flag stays untouched; an illegal operand loads nothing and sets badsel.
          if (dir_hit[0]) state_next.dir_a = state_reg.w; // see [RULE2]
          if (dir_hit[1]) state_next.dir_b = state_reg.w; // see [RULE2]
          if (dir_hit[2]) state_next.dir_c = state_reg.w; // see [RULE2]
          if (!dir_legal) state_next.badsel = 1'b1;       // see [RULE1]
        end
        XDL_OP_XORL: begin
          state_next.w = xor_y;     // see [RULE3]
          state_next.z = xor_zero;  // see [RULE6]
        end
        XDL_OP_XORF: begin
          state_next.z = xor_zero;  // see [RULE4]
          if (dest == XDL_DEST_W) begin
            state_next.w = xor_y;   // see [RULE5]
          end else begin
            state_next.we    = 1'b1; // see [RULE5]
            state_next.waddr = file_addr;
            state_next.wdata = xor_y;
          end
        end
        default: ;
      endcase
    end
    // The read sees the registers as they stood before this edge.
    if (reg_read) begin
      state_next.rdata = read_mux(state_reg, reg_addr);
    end
  end

  // State register with constant reset values.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg        <= '0;
      state_reg.w      <= XDL_W_RESET;
      state_reg.dir_a  <= XDL_DIR_RESET;
      state_reg.dir_b  <= XDL_DIR_RESET;
      state_reg.dir_c  <= XDL_DIR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata        = state_reg.rdata;
  assign file_waddr       = state_reg.waddr;
  assign file_wdata       = state_reg.wdata;
  assign file_we          = state_reg.we;
  assign work_reg         = state_reg.w;
  assign zero_flag        = state_reg.z;
  assign port_a_direction = state_reg.dir_a;
  assign port_b_direction = state_reg.dir_b;
  assign port_c_direction = state_reg.dir_c;

  // Checks on the instruction effects.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Each legal operand copies the old W into its own direction register.
  dir_load_a_a: assert property ( // see [RULE2]
      op_valid && op == XDL_OP_DIR && dir_sel == XDL_SEL_PORT_A
      |=> port_a_direction == $past(work_reg))
    else $error("port A direction not loaded from W");

  dir_load_b_a: assert property ( // see [RULE2]
      op_valid && op == XDL_OP_DIR && dir_sel == XDL_SEL_PORT_B
      |=> port_b_direction == $past(work_reg))
    else $error("port B direction not loaded from W");

  dir_load_c_a: assert property ( // see [RULE2]
      op_valid && op == XDL_OP_DIR && dir_sel == XDL_SEL_PORT_C
      |=> port_c_direction == $past(work_reg))
    else $error("port C direction not loaded from W");

  // A direction load keeps the flag; W may change only by software.
  dir_flags_a: assert property ( // see [RULE1]
      op_valid && op == XDL_OP_DIR
      |=> $stable(zero_flag) && ($stable(work_reg) || $past(reg_write)))
    else $error("direction load changed flags or W");

  dir_nofile_a: assert property ( // see [RULE1]
      op_valid && op == XDL_OP_DIR |=> !file_we)
    else $error("direction load wrote a file byte");

  // An operand outside the legal range loads nothing and is recorded.
  dir_illegal_a: assert property ( // see [RULE1]
      op_valid && op == XDL_OP_DIR && !dir_legal && !reg_write
      |=> $stable(port_a_direction) && $stable(port_b_direction)
      && $stable(port_c_direction))
    else $error("illegal operand changed a direction");

  dir_badsel_a: assert property ( // see [RULE1]
      op_valid && op == XDL_OP_DIR && !dir_legal |=> state_reg.badsel)
    else $error("illegal operand not recorded");

  // The literal form only ever touches W and the zero flag.
  xorl_w_a: assert property ( // see [RULE3]
      op_valid && op == XDL_OP_XORL
      |=> work_reg == ($past(work_reg) ^ $past(literal)))
    else $error("literal XOR result wrong");

  xorl_nofile_a: assert property ( // see [RULE3]
      op_valid && op == XDL_OP_XORL |=> !file_we)
    else $error("literal XOR wrote a file byte");

  xorl_dirs_a: assert property ( // see [RULE3]
      op_valid && op == XDL_OP_XORL && !reg_write
      |=> $stable(port_a_direction) && $stable(port_b_direction)
      && $stable(port_c_direction))
    else $error("literal XOR changed a direction");

  // Zero is worked out from the operands, not from the datapath result.
  xor_zero_a: assert property ( // see [RULE6]
      op_valid && (op == XDL_OP_XORL || op == XDL_OP_XORF)
      |=> zero_flag == (($past(work_reg) ^ ($past(op) == XDL_OP_XORL
      ? $past(literal) : $past(file_rdata))) == 8'h00))
    else $error("zero flag wrong after XOR");

  // Only an exclusive-OR may move the zero flag.
  z_only_xor_a: assert property ( // see [RULE1]
      $changed(zero_flag) |-> $past(op_valid)
      && ($past(op) == XDL_OP_XORL || $past(op) == XDL_OP_XORF))
    else $error("zero flag moved without an XOR");

  // The destination bit steers the file form to W or to the file.
  xorf_file_a: assert property ( // see [RULE5]
      op_valid && op == XDL_OP_XORF && dest == XDL_DEST_FILE
      |=> file_we && file_waddr == $past(file_addr)
      && file_wdata == ($past(work_reg) ^ $past(file_rdata)))
    else $error("file XOR write-back wrong");

  xorf_keep_a: assert property ( // see [RULE4]
      op_valid && op == XDL_OP_XORF && dest == XDL_DEST_FILE && !reg_write
      |=> $stable(work_reg))
    else $error("file destination changed W");

  xorf_wdst_a: assert property ( // see [RULE5]
      op_valid && op == XDL_OP_XORF && dest == XDL_DEST_W
      |=> !file_we && work_reg == ($past(work_reg) ^ $past(file_rdata)))
    else $error("W destination result wrong");

  // A file write appears only after a file XOR aimed at the file.
  we_origin_a: assert property ( // see [RULE5]
      file_we |-> $past(op_valid) && $past(op) == XDL_OP_XORF
      && $past(dest) == XDL_DEST_FILE)
    else $error("file write without a file XOR");

  cov_dir_c: cover property (op_valid && op == XDL_OP_DIR
      && dir_sel == XDL_SEL_PORT_C);
  cov_xorl_zero: cover property (op_valid && op == XDL_OP_XORL && xor_zero);
  cov_xorf_file: cover property (op_valid && op == XDL_OP_XORF
      && dest == XDL_DEST_FILE);
  cov_bad_sel: cover property (op_valid && op == XDL_OP_DIR && !dir_legal);
endmodule

// >>> rtl/xdl_xor_unit.sv
// Exclusive-OR datapath with zero detection.
// Assumes both operands are already valid in the same cycle.
`timescale 1ns/100ps
module xdl_xor_unit
  import xdl_pkg::*;
#(
  parameter int WIDTH = XDL_DATA_W
) (
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  output logic      [WIDTH-1:0] y,
  output logic                  zero
);
  // Pure combinational result; the caller registers it.
  always_comb begin
    y    = a ^ b;
    zero = (y == '0);
  end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the direction-load and exclusive-OR block.
// Assumes the design's registered outputs settle one cycle after a request.
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
  got, exp); end end
module testbench;
  import xdl_pkg::*;
  logic        clock, resetn, op_valid, dest, reg_write, reg_read;
  logic [1:0]  op_code;
  logic [7:0]  literal, file_rdata, reg_wdata, reg_rdata, file_wdata;
  logic [7:0]  work_reg, port_a_direction, port_b_direction;
  logic [7:0]  port_c_direction;
  logic [6:0]  file_addr, file_waddr;
  logic [2:0]  dir_sel;
  logic [3:0]  reg_addr;
  logic        file_we, zero_flag;
  logic [23:0] exp_dirs;
  logic [23:0] dirs;
  int          bad_count, checks_done;

  xdl_exec dut_u (.clock(clock), .resetn(resetn), .op_valid(op_valid),
    .op_code(op_code), .literal(literal), .file_addr(file_addr),
    .dest(dest), .dir_sel(dir_sel), .file_rdata(file_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .file_we(file_we), .work_reg(work_reg),
    .zero_flag(zero_flag), .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction));

  // All three direction registers, port C in the top byte.
  assign dirs = {port_c_direction, port_b_direction, port_a_direction};

  // Free-running 250 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Presents one instruction; the request is held until the next task.
  task automatic op(input logic [1:0] c, input logic [7:0] k,
                    input logic [6:0] a, input logic d,
                    input logic [2:0] s, input logic [7:0] f);
    @(posedge clock);
    op_valid <= 1'b1; reg_write <= 1'b0; reg_read <= 1'b0;
    op_code <= c; literal <= k; file_addr <= a; dest <= d;
    dir_sel <= s; file_rdata <= f;
  endtask

  // Drops every strobe and waits until the last request has landed.
  task automatic settle();
    @(posedge clock);
    op_valid <= 1'b0; reg_write <= 1'b0; reg_read <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    op_valid <= 1'b0; reg_read <= 1'b0; reg_write <= 1'b1;
    reg_addr <= a; reg_wdata <= d;
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    op_valid <= 1'b0; reg_write <= 1'b0; reg_read <= 1'b1; reg_addr <= a;
    settle();
    `CHK(reg_rdata, e)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    bad_count = 0; checks_done = 0; resetn = 1'b0; op_valid = 1'b0;
    op_code = 2'h0; literal = 8'h00; file_addr = 7'h00; dest = 1'b0;
    dir_sel = 3'h0; file_rdata = 8'h00; reg_addr = 4'h0;
    reg_wdata = 8'h00; reg_write = 1'b0; reg_read = 1'b0;
    exp_dirs = 24'hFFFFFF;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rd(XDL_REG_W, 8'h00);
    rd(XDL_REG_DIR_A, 8'hFF);
    // A literal equal to W must clear W and raise zero.
    wr(XDL_REG_W, 8'h3C);
    op(XDL_OP_XORL, 8'h3C, 7'h00, 1'b0, 3'h0, 8'h00);
    settle();
    `CHK({work_reg, zero_flag}, 9'h001)
    // Back to back: the second literal sees the first result.
    op(XDL_OP_XORL, 8'h5A, 7'h00, 1'b0, 3'h0, 8'h00);
    op(XDL_OP_XORL, 8'hFF, 7'h00, 1'b0, 3'h0, 8'h00);
    settle();
    `CHK({work_reg, zero_flag}, 9'h14A)
    // Raise zero again, so the loads below must keep a set flag.
    op(XDL_OP_XORL, 8'hA5, 7'h00, 1'b0, 3'h0, 8'h00);
    settle();
    `CHK({work_reg, zero_flag}, 9'h001)
    // Every legal operand loads its own port and leaves zero alone.
    for (int i = 0; i < 3; i++) begin
      wr(XDL_REG_W, 8'(8'h11 * (i + 1)));
      op(XDL_OP_DIR, 8'h00, 7'h00, 1'b0, 3'(3'h5 + i), 8'h00);
      settle();
      exp_dirs[8*i +: 8] = 8'(8'h11 * (i + 1));
      `CHK(dirs, exp_dirs)
      `CHK(zero_flag, 1'b1)
    end
    // An operand below the legal range loads nothing and is recorded.
    op(XDL_OP_DIR, 8'h00, 7'h00, 1'b0, 3'h4, 8'h00);
    settle();
    `CHK(dirs, exp_dirs)
    rd(XDL_REG_STATUS, 8'h03);
    wr(XDL_REG_STATUS, 8'h01);
    rd(XDL_REG_STATUS, 8'h01);
    // File result written back to the top file address, W untouched.
    op(XDL_OP_XORF, 8'h00, 7'h7F, XDL_DEST_FILE, 3'h0, 8'h33);
    settle();
    `CHK({file_we, file_waddr, file_wdata}, 16'hFF00)
    `CHK({work_reg, zero_flag}, 9'h067)
    // Destination zero sends the result to W and writes no file.
    op(XDL_OP_XORF, 8'h00, 7'h00, XDL_DEST_W, 3'h0, 8'h0F);
    settle();
    `CHK({file_we, work_reg, zero_flag}, 10'h078)
    // An unused code changes nothing, whatever its operands say.
    op(XDL_OP_NONE, 8'hFF, 7'h01, XDL_DEST_FILE, 3'h5, 8'hFF);
    settle();
    `CHK({file_we, work_reg, zero_flag}, 10'h078)
    `CHK(dirs, exp_dirs)
    // A software write to a direction register reads back.
    wr(XDL_REG_DIR_B, 8'h5A);
    rd(XDL_REG_DIR_B, 8'h5A);
    `CHK(dirs, 24'h335A11)
    // Read data stand for one cycle only.
    settle();
    `CHK(reg_rdata, 8'h00)
    // Unmapped offset reads zero and ignores writes.
    wr(4'hF, 8'h55);
    rd(4'hF, 8'h00);
    // A reset in mid-run restores every register.
    @(posedge clock);
    resetn <= 1'b0;
    #1;
    `CHK({work_reg, zero_flag, file_we, reg_rdata}, 18'h00000)
    `CHK(dirs, 24'hFFFFFF)
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(XDL_REG_DIR_B, 8'hFF);
    report_and_stop();
  end
endmodule
